// >>> rtl/aan_advert_regs.sv
// Purpose: Base page advertisement bank with control and status words
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Fields feed the negotiation engine straight from flops
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps

module aan_advert_regs
    import aan_pkg::*;
#(
    parameter int NONCE_W = 5
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // Register port
    input  wire logic [4:0]         reg_devad,
    input  wire logic [15:0]        reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [15:0]        reg_rdata,
    output logic                    reg_rvalid,
    // Configuration pin
    input  wire logic               role_strap,
    // Engine status inputs
    input  wire logic               codeword_rx,
    input  wire logic               negotiation_initiated,
    input  wire logic               negotiation_done_in,
    input  wire logic               link_up,
    input  wire logic [NONCE_W-1:0] nonce_raw,
    // Advertised fields to the engine
    output logic                    next_page_request,
    output logic                    codeword_acknowledge,
    output logic                    remote_fault_advert,
    output logic                    role_forced,
    output logic      [1:0]         pause_ability,
    output logic      [4:0]         protocol_selector,
    output logic                    long_reach_ability,
    output logic                    leader_role_advert,
    output logic      [NONCE_W-1:0] tx_nonce,
    // Negotiation control to the engine
    output logic                    negotiation_restart,
    output logic                    negotiation_enable,
    output logic                    advert_valid
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helper

    // True when the access targets the given offset in our device
    function automatic logic reg_hit(input logic [4:0]  devad,
                                     input logic [15:0] addr,
                                     input logic [15:0] off);
        reg_hit = (devad == AAN_DEVAD) && (addr == off);
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////
    // Storage

    // Low advertisement word fields
    logic       np_ff;
    logic       ack_ff;
    logic       rf_ff;
    logic       force_ff;
    logic [1:0] pause_ff;
    logic [4:0] sel_ff;

    // Middle advertisement word fields
    logic       lr_ff;
    logic       role_ff;

    // Control and status
    logic       en_ff;
    logic       valid_ff;

    // Read port
    logic [15:0] rdata_ff;
    logic        rvalid_ff;
    logic [15:0] nxt_rdata;

    // Transmitted nonce
    logic [NONCE_W-1:0] nonce_ff;

    // Helper nets
    logic wr_low;
    logic wr_mid;
    logic wr_ctrl;
    logic rst_start;
    logic rst_busy;
    logic rst_pulse;
    logic strap_val;
    logic strap_load;

    ////////////////////////////////////////////////////////////////////////
    // Write decode

    // Writes to status or unmapped offsets are dropped
    assign wr_low    = reg_wr && reg_hit(reg_devad, reg_addr, AAN_OFF_LOW);
    assign wr_mid    = reg_wr && reg_hit(reg_devad, reg_addr, AAN_OFF_MID);
    assign wr_ctrl   = reg_wr && reg_hit(reg_devad, reg_addr, AAN_OFF_CTRL);
    assign rst_start = wr_ctrl && reg_wdata[AAN_CTRL_RST];

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    // Role pin caught once after reset release
    aan_strap_latch u_strap (
        .clk      (clk),
        .reset    (reset),
        .strap_in (role_strap),
        .strap_ff (strap_val),
        .load_ff  (strap_load)
    );

    // Self-clearing restart bit
    aan_restart_ctl u_restart (
        .clk       (clk),
        .reset     (reset),
        .start     (rst_start),
        .initiated (negotiation_initiated),
        .busy_ff   (rst_busy),
        .pulse_ff  (rst_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    // Low advertisement word

    // Next page request
    always_ff @(posedge clk) begin
        if (reset) begin
            np_ff <= AAN_RST_LOW[AAN_LOW_NP];
        end else if (wr_low) begin
            np_ff <= reg_wdata[AAN_LOW_NP];
        end
    end

    // Acknowledge: set by a received codeword, dropped on restart
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_ff <= AAN_RST_LOW[AAN_LOW_ACK];
        end else if (codeword_rx) begin
            ack_ff <= 1'b1;
        end else if (rst_pulse) begin
            ack_ff <= 1'b0;
        end
    end

    // Remote fault
    always_ff @(posedge clk) begin
        if (reset) begin
            rf_ff <= AAN_RST_LOW[AAN_LOW_RF];
        end else if (wr_low) begin
            rf_ff <= reg_wdata[AAN_LOW_RF];
        end
    end

    // Forced or preferred role
    always_ff @(posedge clk) begin
        if (reset) begin
            force_ff <= AAN_RST_LOW[AAN_LOW_FORCE];
        end else if (wr_low) begin
            force_ff <= reg_wdata[AAN_LOW_FORCE];
        end
    end

    // Pause ability pair
    always_ff @(posedge clk) begin
        if (reset) begin
            pause_ff <= AAN_RST_LOW[AAN_LOW_PAUSE +: 2];
        end else if (wr_low) begin
            pause_ff <= reg_wdata[AAN_LOW_PAUSE +: 2];
        end
    end

    // Selector is reloaded every cycle and never written
    always_ff @(posedge clk) begin
        sel_ff <= AAN_SELECTOR;
    end

    ////////////////////////////////////////////////////////////////////////
    // Middle advertisement word

    // Long reach ability
    always_ff @(posedge clk) begin
        if (reset) begin
            lr_ff <= AAN_RST_MID[AAN_MID_LR];
        end else if (wr_mid) begin
            lr_ff <= reg_wdata[AAN_MID_LR];
        end
    end

    // Role: pin value after reset, software may override later
    always_ff @(posedge clk) begin
        if (reset) begin
            role_ff <= AAN_RST_MID[AAN_MID_ROLE];
        end else if (wr_mid) begin
            role_ff <= reg_wdata[AAN_MID_ROLE];
        end else if (strap_load) begin
            role_ff <= strap_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and status

    // Negotiation enable
    always_ff @(posedge clk) begin
        if (reset) begin
            en_ff <= AAN_RST_CTRL[AAN_CTRL_EN];
        end else if (wr_ctrl) begin
            en_ff <= reg_wdata[AAN_CTRL_EN];
        end
    end

    // Contents valid only when done, link up and enabled
    always_ff @(posedge clk) begin
        if (reset) begin
            valid_ff <= AAN_RST_STAT[AAN_STAT_DONE];
        end else begin
            valid_ff <= negotiation_done_in && link_up && en_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Nonce with the advertised role inserted

    // Role replaces one bit of the raw nonce from the engine
    always_ff @(posedge clk) begin
        if (reset) begin
            nonce_ff <= '0;
        end else begin
            nonce_ff                 <= nonce_raw;
            nonce_ff[AAN_NONCE_ROLE] <= role_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    // Assemble the addressed word; unset bits stay zero
    always_comb begin
        nxt_rdata = 16'h0000;
        if (reg_hit(reg_devad, reg_addr, AAN_OFF_LOW)) begin
            nxt_rdata[AAN_LOW_NP]         = np_ff;
            nxt_rdata[AAN_LOW_ACK]        = ack_ff;
            nxt_rdata[AAN_LOW_RF]         = rf_ff;
            nxt_rdata[AAN_LOW_FORCE]      = force_ff;
            nxt_rdata[AAN_LOW_PAUSE +: 2] = pause_ff;
            nxt_rdata[AAN_LOW_SEL +: 5]   = sel_ff;
        end else if (reg_hit(reg_devad, reg_addr, AAN_OFF_MID)) begin
            nxt_rdata[AAN_MID_LR]         = lr_ff;
            nxt_rdata[AAN_MID_ROLE]       = role_ff;
        end else if (reg_hit(reg_devad, reg_addr, AAN_OFF_CTRL)) begin
            nxt_rdata[AAN_CTRL_EN]        = en_ff;
            nxt_rdata[AAN_CTRL_RST]       = rst_busy;
        end else if (reg_hit(reg_devad, reg_addr, AAN_OFF_STAT)) begin
            nxt_rdata[AAN_STAT_DONE]      = valid_ff;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_ff  <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= reg_rd ? nxt_rdata : 16'h0000;
            rvalid_ff <= reg_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flop

    // Register port
    assign reg_rdata            = rdata_ff;
    assign reg_rvalid           = rvalid_ff;

    // Advertised fields
    assign next_page_request    = np_ff;
    assign codeword_acknowledge = ack_ff;
    assign remote_fault_advert  = rf_ff;
    assign role_forced          = force_ff;
    assign pause_ability        = pause_ff;
    assign protocol_selector    = sel_ff;
    assign long_reach_ability   = lr_ff;
    assign leader_role_advert   = role_ff;
    assign tx_nonce             = nonce_ff;

    // Negotiation control
    assign negotiation_restart  = rst_pulse;
    assign negotiation_enable   = en_ff;
    assign advert_valid         = valid_ff;

endmodule : aan_advert_regs

// >>> rtl/aan_pkg.sv
// Purpose: Shared constants for the autonegotiation advertisement bank
// Assumes: 16-bit management registers in management device 0x07
// Notes:   Bit positions are ints; values sized to the fields they meet
package aan_pkg;

    // Management device and register offsets
    localparam logic [4:0]  AAN_DEVAD       = 5'h07;
    localparam logic [15:0] AAN_OFF_CTRL    = 16'h0200;
    localparam logic [15:0] AAN_OFF_STAT    = 16'h0201;
    localparam logic [15:0] AAN_OFF_LOW     = 16'h0202;
    localparam logic [15:0] AAN_OFF_MID     = 16'h0203;

    // Values after reset
    localparam logic [15:0] AAN_RST_LOW     = 16'h0001;
    localparam logic [15:0] AAN_RST_MID     = 16'h4000;
    localparam logic [15:0] AAN_RST_CTRL    = 16'h1000;
    localparam logic [15:0] AAN_RST_STAT    = 16'h0000;

    // Field positions of the low advertisement register
    localparam int          AAN_LOW_NP      = 15;
    localparam int          AAN_LOW_ACK     = 14;
    localparam int          AAN_LOW_RF      = 13;
    localparam int          AAN_LOW_FORCE   = 12;
    localparam int          AAN_LOW_PAUSE   = 10;
    localparam int          AAN_LOW_SEL     = 0;

    // Field positions of the middle advertisement register
    localparam int          AAN_MID_LR      = 14;
    localparam int          AAN_MID_ROLE    = 4;

    // Field positions of control and status
    localparam int          AAN_CTRL_EN     = 12;
    localparam int          AAN_CTRL_RST    = 9;
    localparam int          AAN_STAT_DONE   = 5;

    // Role position inside the transmitted nonce
    localparam int          AAN_NONCE_ROLE  = 4;

    // Fixed selector value
    localparam logic [4:0]  AAN_SELECTOR    = 5'h01;

    // Restart sequencer states
    typedef enum logic [1:0] {
        AAN_RS_IDLE = 2'b01,
        AAN_RS_WAIT = 2'b10
    } aan_rst_e;

endpackage : aan_pkg

// >>> rtl/aan_restart_ctl.sv
// Purpose: Self-clearing restart bit and restart pulse to the engine
// Assumes: Engine pulses initiated once negotiation has begun again
// Notes:   A new restart request beats a same-cycle initiated pulse
`timescale 1ns/1ps
module aan_restart_ctl
    import aan_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Request and engine handshake
    input  wire logic start,
    input  wire logic initiated,
    output logic      busy_ff,
    output logic      pulse_ff
);

    aan_rst_e state_ff;
    aan_rst_e nxt_state;

    ////////////////////////////////////////////////////////////////////////
    // Next state: hold the bit until the engine confirms
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            AAN_RS_IDLE: begin
                if (start) nxt_state = AAN_RS_WAIT;
            end
            AAN_RS_WAIT: begin
                if (!start && initiated) nxt_state = AAN_RS_IDLE;
            end
            default: nxt_state = AAN_RS_IDLE;
        endcase
    end

    // State, visible bit and pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= AAN_RS_IDLE;
            busy_ff  <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state == AAN_RS_WAIT);
            pulse_ff <= start;
        end
    end

endmodule : aan_restart_ctl

// >>> rtl/aan_strap_latch.sv
// Purpose: Catch the role configuration pin once after reset release
// Assumes: Pin is stable around reset release
// Notes:   Load pulse lasts one cycle, right after the first free edge
`timescale 1ns/1ps
module aan_strap_latch
    import aan_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Pin and captured value
    input  wire logic strap_in,
    output logic      strap_ff,
    output logic      load_ff
);

    logic taken_ff;

    ////////////////////////////////////////////////////////////////////////
    // Capture the pin at the first edge after reset is released
    always_ff @(posedge clk) begin
        if (reset) begin
            taken_ff <= 1'b0;
            strap_ff <= 1'b0;
            load_ff  <= 1'b0;
        end else begin
            taken_ff <= 1'b1;
            load_ff  <= ~taken_ff;
            if (!taken_ff) begin
                strap_ff <= strap_in;
            end
        end
    end

endmodule : aan_strap_latch

// >>> verification/aan_advert_checker.sv
// Purpose: Port-level assertions for the advertisement bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
module aan_advert_checker
    import aan_pkg::*;
#(
    parameter int NONCE_W = 5
) (
    // Clock, reset and register port
    input wire logic               clk,
    input wire logic               reset,
    input wire logic [4:0]         reg_devad,
    input wire logic [15:0]        reg_addr,
    input wire logic [15:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [15:0]        reg_rdata,
    input wire logic               reg_rvalid,
    // Engine side
    input wire logic               codeword_rx,
    input wire logic               negotiation_done_in,
    input wire logic               link_up,
    input wire logic [NONCE_W-1:0] nonce_raw,
    input wire logic               next_page_request,
    input wire logic               codeword_acknowledge,
    input wire logic               remote_fault_advert,
    input wire logic               role_forced,
    input wire logic [1:0]         pause_ability,
    input wire logic [4:0]         protocol_selector,
    input wire logic               long_reach_ability,
    input wire logic               leader_role_advert,
    input wire logic [NONCE_W-1:0] tx_nonce,
    input wire logic               negotiation_restart,
    input wire logic               negotiation_enable,
    input wire logic               advert_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Write decode per word
    logic dv, wr_ctl, wr_low, wr_mid;
    assign dv     = reg_wr && reg_devad == AAN_DEVAD;
    assign wr_ctl = dv && reg_addr == AAN_OFF_CTRL;
    assign wr_low = dv && reg_addr == AAN_OFF_LOW;
    assign wr_mid = dv && reg_addr == AAN_OFF_MID;

    // Delayed copies of inputs
    logic [15:0]        wd_ff;
    logic [NONCE_W-1:0] nr_ff;
    logic               vin_ff;
    always_ff @(posedge clk) begin
        wd_ff  <= reg_wdata;
        nr_ff  <= nonce_raw;
        vin_ff <= negotiation_done_in && link_up && negotiation_enable;
    end

    ////////////////////////////////////////////////////////////////
    sel_fixed_a: assert property (protocol_selector == AAN_SELECTOR)
        else $error("selector not fixed");
    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    rd_quiet_a: assert property (!reg_rd |=>
        !reg_rvalid && reg_rdata == 0)
        else $error("read data without read");
    low_write_a: assert property (wr_low |=>
        next_page_request == wd_ff[15] && pause_ability == wd_ff[11:10])
        else $error("low word write lost");
    low_flags_a: assert property (wr_low |=>
        remote_fault_advert == wd_ff[13] && role_forced == wd_ff[12])
        else $error("low word flags lost");
    mid_write_a: assert property (wr_mid |=>
        long_reach_ability == wd_ff[14] && leader_role_advert == wd_ff[4])
        else $error("mid word write lost");
    restart_go_a: assert property (wr_ctl && reg_wdata[9] |=>
        negotiation_restart ##1 !negotiation_restart || $past(wr_ctl))
        else $error("restart pulse wrong");
    restart_why_a: assert property (negotiation_restart |->
        $past(wr_ctl))
        else $error("restart without write");
    ack_set_a: assert property (codeword_rx |=> codeword_acknowledge)
        else $error("acknowledge not set");
    nonce_role_a: assert property (!$past(reset) |->
        tx_nonce[4] == $past(leader_role_advert) &&
        tx_nonce[3:0] == nr_ff[3:0])
        else $error("nonce role bit wrong");
    advert_valid_a: assert property (!$past(reset) |->
        advert_valid == vin_ff)
        else $error("valid flag wrong");
endmodule : aan_advert_checker

bind aan_advert_regs aan_advert_checker #(.NONCE_W(NONCE_W)) u_chk (
    .clk, .reset, .reg_devad, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid, .codeword_rx, .negotiation_done_in, .link_up,
    .nonce_raw, .next_page_request, .codeword_acknowledge,
    .remote_fault_advert, .role_forced, .pause_ability, .protocol_selector,
    .long_reach_ability, .leader_role_advert, .tx_nonce,
    .negotiation_restart, .negotiation_enable, .advert_valid);

// >>> verification/aan_advert_regs_tb.sv
// Purpose: Self-checking bench for the advertisement bank
// Assumes: Engine model answers restarts after a set delay
// Notes:   Role pin held high outside t_strap so the role loads as leader
`timescale 1ns/1ps
module aan_advert_regs_tb
    import aan_pkg::*;
;
    logic        clk = 1'h0, reset = 1'h1, role_strap = 1'h1;
    logic [4:0]  reg_devad = AAN_DEVAD, nonce_raw = 5'h00;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000;
    logic        reg_wr = 1'h0, reg_rd = 1'h0, cw_go = 1'h0, link_go = 1'h0;
    logic [3:0]  init_dly = 4'h0;
    logic [15:0] reg_rdata;
    logic [4:0]  protocol_selector, tx_nonce;
    logic [1:0]  pause_ability;
    logic        reg_rvalid, codeword_rx, negotiation_initiated, link_up;
    logic        negotiation_done_in, next_page_request, role_forced;
    logic        codeword_acknowledge, remote_fault_advert, advert_valid;
    logic        long_reach_ability, leader_role_advert, negotiation_enable;
    logic        negotiation_restart;
    int          n_mismatch = 0, comparisons = 0;

    // Clock and units
    always #12.5 clk = ~clk;
    aan_advert_regs #(.NONCE_W(5)) u_aan_advert_regs (.clk, .reset,
        .reg_devad, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reg_rvalid, .role_strap, .codeword_rx, .negotiation_initiated,
        .negotiation_done_in, .link_up, .nonce_raw, .next_page_request,
        .codeword_acknowledge, .remote_fault_advert, .role_forced,
        .pause_ability, .protocol_selector, .long_reach_ability,
        .leader_role_advert, .tx_nonce, .negotiation_restart,
        .negotiation_enable, .advert_valid);
    aan_engine_model u_aan_engine_model (.clk, .reset, .cw_go, .link_go,
        .init_dly, .negotiation_restart, .codeword_rx,
        .negotiation_initiated, .negotiation_done_in, .link_up);

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] g, e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        @(posedge clk);
    endtask : wr
    task automatic rc(input logic [15:0] a, e);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(posedge clk);
        chk("rvalid", reg_rvalid, 16'h0001);
        chk("rdata", reg_rdata, e);
    endtask : rc
    task automatic t_reset;
        rc(AAN_OFF_LOW, 16'h0001);
        rc(AAN_OFF_MID, 16'h4010);
        rc(AAN_OFF_CTRL, 16'h1000);
        rc(AAN_OFF_STAT, 16'h0000);
    endtask : t_reset
    task automatic t_low;
        wr(AAN_OFF_LOW, 16'hffff);
        chk("np", next_page_request, 16'h0001);
        chk("rf", remote_fault_advert, 16'h0001);
        chk("forced", role_forced, 16'h0001);
        chk("pause", pause_ability, 16'h0003);
        chk("sel", protocol_selector, 16'h0001);
        rc(AAN_OFF_LOW, 16'hbc01);
        wr(AAN_OFF_LOW, 16'h0000);
        rc(AAN_OFF_LOW, 16'h0001);
        reg_devad <= 5'h03;
        wr(AAN_OFF_LOW, 16'h8000);
        reg_devad <= AAN_DEVAD;
        rc(AAN_OFF_LOW, 16'h0001);
        rc(16'h0210, 16'h0000);
    endtask : t_low
    task automatic t_mid;
        wr(AAN_OFF_MID, 16'hffff);
        rc(AAN_OFF_MID, 16'h4010);
        nonce_raw <= 5'h0a;
        repeat (2) @(posedge clk);
        chk("nonce", tx_nonce, 16'h001a);
        wr(AAN_OFF_MID, 16'h0000);
        rc(AAN_OFF_MID, 16'h0000);
        chk("nonce", tx_nonce, 16'h000a);
        chk("lr", long_reach_ability, 16'h0000);
    endtask : t_mid
    task automatic t_ack;
        cw_go <= 1'h1;
        @(posedge clk);
        cw_go <= 1'h0;
        repeat (2) @(posedge clk);
        chk("ack", codeword_acknowledge, 16'h0001);
        rc(AAN_OFF_LOW, 16'h4001);
        wr(AAN_OFF_LOW, 16'h0000);
        rc(AAN_OFF_LOW, 16'h4001);
    endtask : t_ack
    task automatic t_valid;
        link_go <= 1'h1;
        repeat (4) @(posedge clk);
        chk("valid", advert_valid, 16'h0001);
        rc(AAN_OFF_STAT, 16'h0020);
        wr(AAN_OFF_CTRL, 16'h0000);
        chk("enable", negotiation_enable, 16'h0000);
        rc(AAN_OFF_STAT, 16'h0000);
        wr(AAN_OFF_CTRL, 16'h1000);
        link_go <= 1'h0;
    endtask : t_valid
    task automatic t_restart;
        int k;
        init_dly <= 4'hc;
        wr(AAN_OFF_CTRL, 16'h1200);
        chk("restart", negotiation_restart, 16'h0001);
        rc(AAN_OFF_CTRL, 16'h1200);
        chk("restart", negotiation_restart, 16'h0000);
        rc(AAN_OFF_LOW, 16'h0001);
        k = 0;
        while (negotiation_initiated !== 1'h1 && k < 40) begin
            @(posedge clk);
            k++;
        end
        chk("initiated", negotiation_initiated, 16'h0001);
        repeat (2) @(posedge clk);
        rc(AAN_OFF_CTRL, 16'h1000);
        init_dly <= 4'h0;
        wr(AAN_OFF_CTRL, 16'h1200);
        repeat (3) @(posedge clk);
        rc(AAN_OFF_CTRL, 16'h1000);
    endtask : t_restart
    // Mid-run reset with the role pin low: role follows the pin
    task automatic t_strap;
        wr(AAN_OFF_MID, 16'h0010);
        role_strap <= 1'h0;
        reset      <= 1'h1;
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        repeat (3) @(posedge clk);
        chk("role", leader_role_advert, 16'h0000);
        chk("nonce", tx_nonce, 16'h000a);
        rc(AAN_OFF_MID, 16'h4000);
        rc(AAN_OFF_CTRL, 16'h1000);
        role_strap <= 1'h1;
    endtask : t_strap
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        repeat (3) @(posedge clk);
        t_reset();
        t_low();
        t_mid();
        t_ack();
        t_valid();
        t_restart();
        t_strap();
        summarize();
    end
    // Watchdog
    initial begin
        #75000;
        n_mismatch++;
        summarize();
    end
endmodule : aan_advert_regs_tb

// >>> verification/aan_engine_model.sv
// Purpose: Behavioural negotiation engine facing the bank
// Assumes: Bench sets the restart answer delay
// Notes:   Done drops while a restart is pending
`timescale 1ns/1ps
module aan_engine_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Bench commands
    input  wire logic       cw_go,
    input  wire logic       link_go,
    input  wire logic [3:0] init_dly,
    // Bank side
    input  wire logic       negotiation_restart,
    output logic            codeword_rx,
    output logic            negotiation_initiated,
    output logic            negotiation_done_in,
    output logic            link_up
);
    logic [3:0] cnt_ff;
    logic       pend_ff;

    // Answer a restart after the set delay, report link state
    always_ff @(posedge clk) begin
        codeword_rx           <= cw_go && !reset;
        link_up               <= link_go && !reset;
        negotiation_done_in   <= link_go && !pend_ff && !reset;
        negotiation_initiated <= 1'h0;
        if (reset) begin
            pend_ff <= 1'h0;
            cnt_ff  <= 4'h0;
        end else if (negotiation_restart) begin
            pend_ff <= 1'h1;
            cnt_ff  <= init_dly;
        end else if (pend_ff && cnt_ff == 4'h0) begin
            pend_ff               <= 1'h0;
            negotiation_initiated <= 1'h1;
        end else if (pend_ff) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
endmodule : aan_engine_model
